//--- core/sdac_pkg.sv
// Package with constants and types for the serial DAC input logic
package sdac_pkg;
    // Code width kept in the DAC register
    localparam int SDAC_CODE_W = 14;
    // Longest serial word the shift register holds
    localparam int SDAC_SHIFT_W = 16;
    // Segmented top bits of the code
    localparam int SDAC_SEG_BITS = 3;
    // Thermometer elements for the segmented top bits
    localparam int SDAC_SEG_N = 7;
    // Binary legs below the segments
    localparam int SDAC_BIN_W = SDAC_CODE_W - SDAC_SEG_BITS;
    // Power-up value of the DAC register
    localparam logic [13:0] SDAC_CODE_RST = 14'h0000;
    // Reset value of the shift register
    localparam logic [15:0] SDAC_SHIFT_RST = 16'h0000;

    // Frame state of the serial port
    typedef enum logic [0:0] {
        SDAC_IDLE,
        SDAC_FRAME
    } sdac_state_t;

    // Ladder switch drive: 1 steers a leg to current_output, 0 to ground
    typedef struct packed {
        logic [SDAC_SEG_N-1:0] seg_leg;
        logic [SDAC_BIN_W-1:0] bin_leg;
    } sdac_ladder_t;
endpackage : sdac_pkg

//--- core/sdac_seg_decode.sv
// Thermometer decoder for the segmented top code bits
`timescale 1ns/1ps
module sdac_seg_decode
    import sdac_pkg::*;
#(
    parameter int IN_W = SDAC_SEG_BITS,
    parameter int OUT_N = SDAC_SEG_N
)
(
    // Binary input
    input wire logic [IN_W-1:0] bin_in,
    // Thermometer output, element k on when value exceeds k
    output logic [OUT_N-1:0] therm_out
);
    ////////////////////////////////////////////////////////////////////
    // Each element is an equal-weight segment
    always_comb
    begin
        for (int k = 0; k < OUT_N; k++)
        begin
            therm_out[k] = (32'(bin_in) > k);
        end
    end
endmodule : sdac_seg_decode

//--- core/sdac_input_logic.sv
// Serial input, DAC register and ladder switch drive of the DAC
`timescale 1ns/1ps
// Summary of operation
// - Shift one bit per clock while selected
// - Select rising edge copies shift register out
// - DAC register changes only on select rise
// - Accept up to 16 bits, keep last 14
// - Top three bits drive segmented elements
// - Each leg switched to ground or output
// - Data sampled on rising serial clock
// - Earlier leading bits are discarded
module sdac_input_logic
    import sdac_pkg::*;
#(
    parameter int CODE_W = SDAC_CODE_W,
    parameter int SHIFT_W = SDAC_SHIFT_W
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial port, sampled on clk
    input wire logic serial_data_in,
    input wire logic chip_select_n,
    // DAC register and ladder drive
    output logic [CODE_W-1:0] dac_code,
    output sdac_ladder_t ladder_sw,
    // Current frame bit count, saturating
    output logic [4:0] frame_bits
);
    ////////////////////////////////////////////////////////////////////
    // State
    sdac_state_t state_ff; // Frame tracker
    sdac_state_t nxt_state;
    logic [SHIFT_W-1:0] shift_ff; // Serial shift register
    logic [SHIFT_W-1:0] nxt_shift;
    logic [CODE_W-1:0] code_ff; // DAC register
    logic [CODE_W-1:0] nxt_code;
    logic [4:0] cnt_ff; // Bits in current frame
    logic [4:0] nxt_cnt;
    logic cs_d_ff; // Select as seen last edge
    logic cs_rise; // Select just went high
    sdac_ladder_t ladder_ff; // Registered switch drive
    sdac_ladder_t nxt_ladder;
    logic [SDAC_SEG_N-1:0] seg_therm;

    // Select edge seen against its previous sample
    assign cs_rise = chip_select_n && !cs_d_ff;

    ////////////////////////////////////////////////////////////////////
    // Next-value logic for the serial side
    always_comb
    begin
        nxt_state = state_ff;
        nxt_shift = shift_ff;
        nxt_cnt = cnt_ff;
        nxt_code = code_ff;
        case (state_ff)
            SDAC_IDLE:
            begin
                // Select high: shift register untouched
                if (!chip_select_n)
                begin
                    nxt_state = SDAC_FRAME;
                    nxt_shift = {shift_ff[SHIFT_W-2:0], serial_data_in};
                    nxt_cnt = 5'h01;
                end
            end
            SDAC_FRAME:
            begin
                if (!chip_select_n)
                begin
                    // Oldest bit falls off the top: MSB-first order
                    nxt_shift = {shift_ff[SHIFT_W-2:0], serial_data_in};
                    // Saturates so a long stream never wraps to a small
                    // count that would look like a fresh short frame
                    if (cnt_ff != 5'h1f)
                    begin
                        nxt_cnt = cnt_ff + 5'h01;
                    end
                end
                else
                begin
                    // Frame closed by select rising
                    nxt_state = SDAC_IDLE;
                end
            end
            default:
            begin
                nxt_state = SDAC_IDLE;
            end
        endcase
        // Only a select rise loads; low bits are the last 14 shifted
        if (cs_rise)
        begin
            nxt_code = shift_ff[CODE_W-1:0];
        end
    end

    // Registers for the serial side
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= SDAC_IDLE;
            shift_ff <= SDAC_SHIFT_RST;
            cnt_ff <= 5'h00;
            code_ff <= SDAC_CODE_RST;
            cs_d_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            shift_ff <= nxt_shift;
            cnt_ff <= nxt_cnt;
            code_ff <= nxt_code;
            cs_d_ff <= chip_select_n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Ladder drive; segments decoded from the top code bits
    sdac_seg_decode #(
        .IN_W(SDAC_SEG_BITS),
        .OUT_N(SDAC_SEG_N)
    ) u_seg (
        .bin_in(code_ff[CODE_W-1 -: SDAC_SEG_BITS]),
        .therm_out(seg_therm)
    );

    // Switch pattern follows the DAC register
    always_comb
    begin
        nxt_ladder.seg_leg = seg_therm;
        nxt_ladder.bin_leg = code_ff[SDAC_BIN_W-1:0];
    end

    // Registered so switches move glitch-free, one cycle after the code
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ladder_ff <= '0;
        end
        else
        begin
            ladder_ff <= nxt_ladder;
        end
    end

    assign dac_code = code_ff;
    assign ladder_sw = ladder_ff;
    assign frame_bits = cnt_ff;

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence seq_shift_step;
        !chip_select_n;
    endsequence

    property prop_shift;
        @(posedge clk) disable iff (!rst_n)
        seq_shift_step |=> shift_ff == {$past(shift_ff[SHIFT_W-2:0]),
                                        $past(serial_data_in)};
    endproperty

    AST_SHIFT_ADV: assert property (prop_shift)
        else $error("Shift register did not advance");

    AST_SHIFT_HOLD: assert property (
        @(posedge clk) disable iff (!rst_n)
        chip_select_n |=> $stable(shift_ff))
        else $error("Shift register moved while deselected");

    AST_LOAD: assert property (
        @(posedge clk) disable iff (!rst_n)
        (chip_select_n && !cs_d_ff) |=>
            code_ff == $past(shift_ff[CODE_W-1:0]))
        else $error("DAC register not loaded on select rise");

    AST_LATCH: assert property (
        @(posedge clk) disable iff (!rst_n)
        !(chip_select_n && !cs_d_ff) |=> $stable(code_ff))
        else $error("DAC register changed without select rise");

    // Last low edge samples the final bit, the rise edge loads it, and the
    // check runs one edge later: the final bit is two edges back
    AST_LAST14: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!chip_select_n [*8] ##1 chip_select_n) |=>
            code_ff[0] == $past(serial_data_in, 2))
        else $error("Last bit shifted is not code bit zero");

    AST_SEG: assert property (
        @(posedge clk) disable iff (!rst_n)
        ##1 $countones(ladder_sw.seg_leg) ==
            $past(32'(code_ff[CODE_W-1 -: SDAC_SEG_BITS])))
        else $error("Segment count does not match top bits");

    // Segments fill from the bottom; a gap would break monotonic steps
    AST_SEG_THERM: assert property (
        @(posedge clk) disable iff (!rst_n)
        $onehot0(ladder_sw.seg_leg ^ (ladder_sw.seg_leg >> 1)))
        else $error("Segment drive is not a thermometer pattern");

    AST_LEGS: assert property (
        @(posedge clk) disable iff (!rst_n)
        ##1 ladder_sw.bin_leg == $past(code_ff[SDAC_BIN_W-1:0]))
        else $error("Binary legs do not follow the code");

    AST_DISCARD: assert property (
        @(posedge clk) disable iff (!rst_n)
        (chip_select_n && !cs_d_ff) |=>
            code_ff[CODE_W-1] == $past(shift_ff[CODE_W-1]))
        else $error("Top code bit not from bit 13 of shifter");

    AST_RESET_ZERO: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> code_ff == SDAC_CODE_RST)
        else $error("DAC register not zero after reset");
endmodule : sdac_input_logic

//--- test/sdac_host_model.sv
// Host model driving the three-wire serial port of the DAC
`timescale 1ns/1ps
module sdac_host_model
(
    // Clock
    input wire logic clk,
    // Serial port toward the device
    output logic serial_data_in,
    output logic chip_select_n
);
    logic framing; // High while a word goes out
    initial
    begin
        serial_data_in = 1'b0;
        chip_select_n = 1'b1;
        framing = 1'b0;
    end
    // Idle data toggles so a stray sample never looks like a valid bit
    always @(negedge clk)
    begin
        if (!framing)
            serial_data_in <= ~serial_data_in;
    end
    // Send n bits of w, top bit first, then raise select
    task automatic send(input logic [15:0] w, input int n);
        @(posedge clk);
        framing = 1'b1;
        for (int i = n - 1; i >= 0; i--)
        begin
            @(negedge clk);
            chip_select_n <= 1'b0;
            serial_data_in <= w[i];
        end
        @(negedge clk);
        chip_select_n <= 1'b1;
        @(posedge clk);
        framing = 1'b0;
    endtask : send
endmodule : sdac_host_model

//--- test/testbench.sv
// Self-checking bench for the serial DAC input logic
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module testbench
    import sdac_pkg::*;
;
    logic clk;
    logic rst_n;
    logic serial_data_in;
    logic chip_select_n;
    logic [13:0] dac_code;
    sdac_ladder_t ladder_sw;
    logic [4:0] frame_bits;
    logic [15:0] sh_m; // Shadow of the shift register
    logic [31:0] lfsr;
    int checks = 0;
    int fail_count = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////
    sdac_input_logic dut_u (
        .clk(clk),
        .rst_n(rst_n),
        .serial_data_in(serial_data_in),
        .chip_select_n(chip_select_n),
        .dac_code(dac_code),
        .ladder_sw(ladder_sw),
        .frame_bits(frame_bits)
    );
    sdac_host_model host_u (
        .clk(clk),
        .serial_data_in(serial_data_in),
        .chip_select_n(chip_select_n)
    );
    ////////////////////////////////////////////////////////////////////
    initial clk = 1'b0;
    always #50 clk = ~clk;
    // Hang guard, well above the length of the frame list
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            test_done();
        end
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // Expected switch drive: thermometer top, binary legs below
    function automatic sdac_ladder_t ladder_of(input logic [13:0] c);
        sdac_ladder_t l;
        for (int k = 0; k < SDAC_SEG_N; k++)
            l.seg_leg[k] = (c[13:11] > k);
        l.bin_leg = c[SDAC_BIN_W-1:0];
        return l;
    endfunction : ladder_of
    task automatic test_done();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // One word through the port, then code, count, ladder and hold
    task automatic frame(input logic [15:0] w, input int n);
        host_u.send(w, n);
        for (int i = n - 1; i >= 0; i--)
            sh_m = {sh_m[14:0], w[i]};
        @(negedge clk);
        `CHK("dac_code", sh_m[13:0], dac_code)
        `CHK("frame_bits", 5'(n), frame_bits)
        @(negedge clk);
        `CHK("ladder_sw", ladder_of(sh_m[13:0]), ladder_sw)
        repeat (3) @(negedge clk);
        `CHK("dac_hold", sh_m[13:0], dac_code)
    endtask : frame
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_n = 1'b0;
        lfsr = 32'h220cda6f;
        sh_m = SDAC_SHIFT_RST;
        repeat (6) @(negedge clk);
        `CHK("dac_rst", SDAC_CODE_RST, dac_code)
        `CHK("ladder_rst", 18'h0, ladder_sw)
        rst_n <= 1'b1;
        frame(16'hffff, 16);
        frame(16'h0000, 14);
        // Short word: upper code bits come from older contents
        frame(16'h2aaa, 3);
        frame(16'h3fff, 15);
        for (int i = 0; i < 40; i++)
        begin
            lfsr = lfsr_next(lfsr);
            frame(lfsr[15:0], 1 + lfsr[19:16]);
        end
        rst_n <= 1'b0;
        @(negedge clk);
        `CHK("dac_rst2", SDAC_CODE_RST, dac_code)
        `CHK("ladder_rst2", 18'h0, ladder_sw)
        // Second release mid-run; shadow follows the cleared shifter
        sh_m = SDAC_SHIFT_RST;
        rst_n <= 1'b1;
        frame(16'h1234, 5);
        test_done();
    end
endmodule : testbench
